// >>> link_master_model.sv
`timescale 1ns/100ps
// Bus master model: one request per call
module link_master_model (
  input  logic        clock,
  output logic        req_valid = 1'b0,
  output logic [7:0]  req_func = 8'h00,
  output logic [15:0] req_addr = 16'h0000,
  output logic [15:0] req_data = 16'h0000
);
  // Strobe one edge, then idle lines show the inverse
  task send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    req_valid <= 1'b1;
    req_func <= f;
    req_addr <= a;
    req_data <= d;
    @(posedge clock);
    req_valid <= 1'b0;
    req_func <= ~f;
    req_addr <= ~a;
    req_data <= ~d;
  endtask
endmodule

// >>> serial_link_settings_bank.v
// Operation
// - Four consecutive read/write holding registers hold the serial link settings.
// - Reads use function 0x03 and the bank answers it for these addresses.
// - Writes use function 0x06 and the bank accepts it for these addresses.
// - The slave address accepts 1 to 247 and resets to 1.
// - Format code 0 means 8 data bits, even parity, 1 stop bit, and is the reset value.
// - Format code 1 means 8 data bits, odd parity, 1 stop bit.
// - Format code 2 means 8 data bits, no parity, 2 stop bits.
// - Format code 3 means 8 data bits, no parity, 1 stop bit, flagged non-conforming.
// - An out-of-range write leaves the register unchanged and returns exception 04.
// - Line rate accepts only 0 (9600) and 1 (19200, default); other codes fail.
// - A write session ends 15 seconds after access was granted.
// - A new slave address never takes effect: reset reloads slave_address_r with 1 before it is latched.
`timescale 1ns/100ps
`include "serial_link_settings_consts.vh"

module serial_link_settings_bank #(
  parameter [31:0] SESSION_CYCLES = `SESSION_TIME_S * `CLOCK_HZ
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        req_valid,
  input  wire [7:0]  req_func,
  input  wire [15:0] req_addr,
  input  wire [15:0] req_data,
  input  wire        access_grant,
  output reg         rsp_valid,
  output reg         rsp_exception,
  output reg  [7:0]  rsp_code,
  output reg  [15:0] rsp_data,
  output reg         session_active,
  output reg         link_on,
  output reg  [7:0]  active_slave_address,
  output reg         line_rate_19200,
  output reg         parity_enable,
  output reg         parity_odd,
  output reg         two_stop_bits,
  output reg         format_nonconforming
);

  // ****************************************
  // Register storage
  // ****************************************
  reg [15:0] link_enable_r;
  reg [15:0] slave_address_r;
  reg [15:0] line_rate_select_r;
  reg [15:0] frame_format_select_r;
  reg [31:0] session_cnt_r;
  reg        restart_done_r;

  reg        hit;
  reg        in_range;
  reg [15:0] rd_val;

  // Reset view of the live settings, drawn from the register defaults
  localparam [15:0] RST_ADDR_WORD = `RST_SLAVE_ADDRESS;
  localparam [15:0] RST_LINK_WORD = `RST_LINK_ENABLE;
  localparam [15:0] RST_RATE_WORD = `RST_LINE_RATE;

  // ****************************************
  // Request decode
  // ****************************************

  // Address decode, read mux and range check
  always @* begin
    hit      = 1'b1;
    in_range = 1'b0;
    rd_val   = 16'h0000;
    case (req_addr)
      `ADDR_LINK_ENABLE: begin
        rd_val   = link_enable_r;
        in_range = (req_data <= `LINK_ENABLE_MAX);
      end
      `ADDR_SLAVE_ADDRESS: begin
        rd_val   = slave_address_r;
        in_range = (req_data >= `SLAVE_ADDR_MIN) && (req_data <= `SLAVE_ADDR_MAX);
      end
      `ADDR_LINE_RATE: begin
        rd_val   = line_rate_select_r;
        in_range = (req_data <= `LINE_RATE_MAX);
      end
      `ADDR_FRAME_FORMAT: begin
        rd_val   = frame_format_select_r;
        in_range = (req_data <= `FRAME_FORMAT_MAX);
      end
      default: hit = 1'b0;
    endcase
  end

  // ****************************************
  // Request qualifiers
  // ****************************************

  // A write lands only inside an open session and with a legal value
  wire do_read  = req_valid && (req_func == `FC_READ_HOLDING);
  wire do_write = req_valid && (req_func == `FC_WRITE_SINGLE);
  wire wr_ok    = do_write && hit && session_active && in_range;

  // ****************************************
  // Setting registers
  // ****************************************

  // Register writes, only inside a session and only with legal values
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_enable_r         <= `RST_LINK_ENABLE;
      slave_address_r       <= `RST_SLAVE_ADDRESS;
      line_rate_select_r    <= `RST_LINE_RATE;
      frame_format_select_r <= `RST_FRAME_FORMAT;
    end else if (wr_ok) begin
      case (req_addr)
        `ADDR_LINK_ENABLE:   link_enable_r         <= req_data;
        `ADDR_SLAVE_ADDRESS: slave_address_r       <= req_data;
        `ADDR_LINE_RATE:     line_rate_select_r    <= req_data;
        `ADDR_FRAME_FORMAT:  frame_format_select_r <= req_data;
        default:             link_enable_r         <= link_enable_r;
      endcase
    end
  end

  // ****************************************
  // Write session
  // ****************************************

  // Session timer: grant opens it, expiry closes it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      session_active <= 1'b0;
      session_cnt_r  <= 32'h0000_0000;
    end else if (access_grant) begin
      session_active <= 1'b1;
      session_cnt_r  <= SESSION_CYCLES;
    end else if (session_active) begin
      if (session_cnt_r <= 32'h0000_0001) begin
        session_active <= 1'b0;
        session_cnt_r  <= 32'h0000_0000;
      end else begin
        session_cnt_r  <= session_cnt_r - 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************

  // Response generation, one cycle after the request
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid     <= 1'b0;
      rsp_exception <= 1'b0;
      rsp_code      <= 8'h00;
      rsp_data      <= 16'h0000;
    end else begin
      rsp_valid     <= req_valid;
      rsp_exception <= 1'b0;
      rsp_code      <= req_func;
      rsp_data      <= 16'h0000;
      if (do_read && hit) begin
        rsp_data <= rd_val;
      end else if (do_write && hit && in_range && session_active) begin
        rsp_data <= req_data;
      end else if (do_write && hit) begin
        rsp_exception <= 1'b1;
        rsp_code      <= `EXC_DEVICE_FAILURE;
      end else if (do_read || do_write) begin
        rsp_exception <= 1'b1;
        rsp_code      <= `EXC_ILLEGAL_ADDR;
      end else begin
        rsp_exception <= req_valid;
        rsp_code      <= req_valid ? `EXC_ILLEGAL_FUNC : 8'h00;
      end
    end
  end

  // ****************************************
  // Live line settings
  // ****************************************

  // Live line settings; the bus address is latched once after reset release
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      restart_done_r       <= 1'b0;
      active_slave_address <= RST_ADDR_WORD[7:0];
      link_on              <= RST_LINK_WORD[0];
      line_rate_19200      <= RST_RATE_WORD[0];
      parity_enable        <= 1'b1;
      parity_odd           <= 1'b0;
      two_stop_bits        <= 1'b0;
      format_nonconforming <= 1'b0;
    end else begin
      restart_done_r <= 1'b1;
      if (!restart_done_r)
        active_slave_address <= slave_address_r[7:0];
      link_on         <= link_enable_r[0];
      line_rate_19200 <= line_rate_select_r[0];
      case (frame_format_select_r[1:0])
        `FMT_8E1: begin
          parity_enable        <= 1'b1;
          parity_odd           <= 1'b0;
          two_stop_bits        <= 1'b0;
          format_nonconforming <= 1'b0;
        end
        `FMT_8O1: begin
          parity_enable        <= 1'b1;
          parity_odd           <= 1'b1;
          two_stop_bits        <= 1'b0;
          format_nonconforming <= 1'b0;
        end
        `FMT_8N2: begin
          parity_enable        <= 1'b0;
          parity_odd           <= 1'b0;
          two_stop_bits        <= 1'b1;
          format_nonconforming <= 1'b0;
        end
        default: begin
          parity_enable        <= 1'b0;
          parity_odd           <= 1'b0;
          two_stop_bits        <= 1'b0;
          format_nonconforming <= 1'b1;
        end
      endcase
    end
  end

endmodule

// >>> serial_link_settings_bank_tb.sv
`timescale 1ns/100ps
module serial_link_settings_bank_tb;
  logic clock = 0, rst_n = 0, access_grant = 0;
  wire req_valid, rsp_valid, rsp_exception, session_active, link_on, line_rate_19200;
  wire parity_enable, parity_odd, two_stop_bits, format_nonconforming;
  wire [7:0] req_func, rsp_code, active_slave_address;
  wire [15:0] req_addr, req_data, rsp_data;
  int error_cnt, total_checks, cyc, exp_r[4] = '{1, 1, 1, 0}, lim[4] = '{1, 247, 1, 3};
  bit sess;
  localparam int SESS = 20;
  initial forever #4 clock = ~clock;
  link_master_model mst (.clock, .req_valid, .req_func, .req_addr, .req_data);
  serial_link_settings_bank #(.SESSION_CYCLES(SESS)) dut (.clock, .rst_n, .req_valid,
    .req_func, .req_addr, .req_data, .access_grant, .rsp_valid, .rsp_exception, .rsp_code,
    .rsp_data, .session_active, .link_on, .active_slave_address, .line_rate_19200,
    .parity_enable, .parity_odd, .two_stop_bits, .format_nonconforming);
  task ck(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // Model one request, send it, compare the answer
  task xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    int i;
    logic [7:0] ec;
    i = a - 16'hc6d5;
    ec = f;
    if (f != 8'h03 && f != 8'h06) ec = 8'h01;
    else if (i < 0 || i > 3) ec = 8'h02;
    else if (f == 8'h06 && (!sess || d > lim[i] || (i == 1 && d == 0))) ec = 8'h04;
    else if (f == 8'h06) exp_r[i] = d;
    mst.send(f, a, d);
    #1;
    ck(rsp_valid === 1'b1 && rsp_code === ec && rsp_exception === (ec != f),
      "answer code");
    ck(rsp_data === (ec != f ? 16'h0 : f == 8'h06 ? d : exp_r[i][15:0]),
      "answer data");
  endtask
  // Setting outputs one cycle after the answer
  task outs;
    @(posedge clock);
    #1;
    ck(link_on === exp_r[0][0] && line_rate_19200 === exp_r[2][0], "link and rate");
    ck(parity_enable === (exp_r[3] < 2) && parity_odd === (exp_r[3] == 1), "parity");
    ck(two_stop_bits === (exp_r[3] == 2) && format_nonconforming === (exp_r[3] == 3),
      "stop bits");
    ck(active_slave_address === 8'h01, "bus address");
  endtask
  // Session stays open for SESS cycles after the grant edge, then closes
  task sess_walk;
    @(posedge clock);
    access_grant <= 1'b1;
    @(posedge clock);
    access_grant <= 1'b0;
    sess = 1;
    for (int k = 0; k <= SESS; k++) begin
      #1;
      ck(session_active === (k < SESS), "session length");
      @(posedge clock);
    end
    sess = 0;
  endtask
  task grant;
    @(posedge clock);
    access_grant <= 1'b1;
    @(posedge clock);
    access_grant <= 1'b0;
    sess = 1;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge clock) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  initial begin
    void'($urandom(32'h7539));
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    outs;
    for (int k = 0; k < 4; k++) xfer(8'h03, 16'hc6d5 + k[15:0], 16'h0);
    xfer(8'h06, 16'hc6d8, 16'h0002);
    grant;
    for (int k = 3; k >= 0; k--) begin
      xfer(8'h06, 16'hc6d8, k[15:0]);
      outs;
    end
    grant;
    xfer(8'h06, 16'hc6d7, 16'h0003);
    xfer(8'h06, 16'hc6d7, 16'h0000);
    xfer(8'h06, 16'hc6d6, 16'h00f8);
    xfer(8'h06, 16'hc6d6, 16'h00f7);
    xfer(8'h06, 16'hc6d5, 16'h0002);
    xfer(8'h06, 16'hc6d5, 16'h0000);
    outs;
    xfer(8'h03, 16'hc6d9, 16'h0);
    xfer(8'h10, 16'hc6d5, 16'h0);
    repeat (40) begin
      grant;
      xfer($urandom_range(1) ? 8'h06 : 8'h03, 16'hc6d5 + 16'($urandom_range(3)),
        16'($urandom_range(260)));
    end
    sess_walk;
    repeat (25) @(posedge clock);
    sess = 0;
    xfer(8'h06, 16'hc6d5, 16'h0000);
    report_and_stop;
  end
endmodule

// >>> serial_link_settings_consts.vh
`ifndef SERIAL_LINK_SETTINGS_CONSTS_VH
`define SERIAL_LINK_SETTINGS_CONSTS_VH
// ****************************************
// Register addresses (protocol addresses)
// ****************************************
`define ADDR_LINK_ENABLE   16'hc6d5
`define ADDR_SLAVE_ADDRESS 16'hc6d6
`define ADDR_LINE_RATE     16'hc6d7
`define ADDR_FRAME_FORMAT  16'hc6d8
// ****************************************
// Function and exception codes
// ****************************************
`define FC_READ_HOLDING    8'h03
`define FC_WRITE_SINGLE    8'h06
`define EXC_ILLEGAL_FUNC   8'h01
`define EXC_ILLEGAL_ADDR   8'h02
`define EXC_DEVICE_FAILURE 8'h04
// ****************************************
// Reset values and limits
// ****************************************
`define RST_LINK_ENABLE    16'h0001
`define RST_SLAVE_ADDRESS  16'h0001
`define RST_LINE_RATE      16'h0001
`define RST_FRAME_FORMAT   16'h0000
`define SLAVE_ADDR_MIN     16'h0001
`define SLAVE_ADDR_MAX     16'h00f7
`define LINK_ENABLE_MAX    16'h0001
`define LINE_RATE_MAX      16'h0001
`define FRAME_FORMAT_MAX   16'h0003
// ****************************************
// Frame format codes
// ****************************************
`define FMT_8E1            2'h0
`define FMT_8O1            2'h1
`define FMT_8N2            2'h2
`define FMT_8N1            2'h3
// ****************************************
// Session timing
// ****************************************
`define SESSION_TIME_S     15
`define CLOCK_HZ           125000000
`endif

// >>> serial_link_settings_sva.sv
`timescale 1ns/100ps
// Port checks of the settings bank
module serial_link_settings_sva (
  input logic        clock,
  input logic        rst_n,
  input logic        req_valid,
  input logic [7:0]  req_func,
  input logic [15:0] req_addr,
  input logic [15:0] req_data,
  input logic        access_grant,
  input logic        rsp_valid,
  input logic        rsp_exception,
  input logic [7:0]  rsp_code,
  input logic [15:0] rsp_data,
  input logic        session_active,
  input logic [7:0]  active_slave_address,
  input logic        two_stop_bits
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Mapped request and open-session write
  wire m = req_valid && req_addr >= 16'hc6d5 && req_addr <= 16'hc6d8;
  wire w = m && req_func == 8'h06 && session_active;
  AST_ANSWER: assert property (req_valid |=> rsp_valid) else $error("no answer");
  AST_READ: assert property (m && req_func == 8'h03 |=> rsp_code == 8'h03) else $error("read");
  AST_ECHO: assert property (w && req_addr == 16'hc6d8 && req_data < 4
    |=> rsp_code == 8'h06 && rsp_data == $past(req_data)) else $error("echo");
  AST_NO_SESSION: assert property (m && req_func == 8'h06 && !session_active
    |=> rsp_exception && rsp_code == 8'h04) else $error("closed write");
  AST_RATE: assert property (w && req_addr == 16'hc6d7 && req_data > 1
    |=> rsp_code == 8'h04) else $error("rate");
  AST_SLAVE: assert property (w && req_addr == 16'hc6d6 && (req_data == 0 || req_data > 247)
    |=> rsp_code == 8'h04) else $error("slave address");
  AST_FORMAT: assert property (w && req_addr == 16'hc6d8 && req_data == 2
    |=> ##1 two_stop_bits) else $error("format");
  AST_HOLD: assert property ($stable(active_slave_address)) else $error("address moved");
  AST_GRANT: assert property (access_grant |=> session_active) else $error("session");
endmodule
bind serial_link_settings_bank serial_link_settings_sva chk (.clock, .rst_n, .req_valid,
  .req_func, .req_addr, .req_data, .access_grant, .rsp_valid, .rsp_exception, .rsp_code,
  .rsp_data, .session_active, .active_slave_address, .two_stop_bits);
